// ==== hw/mlsc_regs.v ====
/*
 MAC link status and configuration register slice behind an APB slave.
 Holds partner ability, PHY status summary, receive maximum length,
 extended command and receive descriptor ring base; polls six PHY
 management registers continuously. Assumes a 100 MHz pclk and all
 inputs synchronous to it; the MDIO pin is resolved outside.
*/
//
// Functional notes
// - Partner ability bit 15 shows partner has a next page to send.
// - Ack bit set after three consecutive matching pages, ack ignored.
// - Bits 13:12 hold partner remote fault code, reset 00.
// - Bits 8:7 show partner asymmetric and symmetric pause ability.
// - Bit 6 shows partner half duplex ability.
// - Bit 5 shows partner full duplex ability.
// - Status bit 7 selects ten-bit interface, loaded from serial memory.
// - Status bits 6 and 5 show transmit and receive flow control.
// - Bits 4,3,2 flag gigabit full, 100 and 10 Mbit speeds.
// - Status bit 1 is link up, bit 0 full duplex.
// - Poll six PHY registers, each 64 management clocks of 320 ns.
// - Receive max size 13:0 must be nonzero to receive frames.
// - Command bit 9 big endian; bit 8 reads zero.
// - Command bit 6 enables receive tag stripping.
// - Command bit 5 enables receive checksum offload.
// - Bit 4 uses dual-address cycles only for nonzero upper address.
// - Bit 3 uses multiple read/write commands, ignoring burst sizes.
// - Command register takes only writes enabling byte lanes 1:0; byte writes ignored.
// - Ring base is 64-bit, 256-byte aligned, low word first.
`timescale 1ns/1ps
`include "mlsc_defines.vh"

module mlsc_regs
#(
  parameter PHY_ADDR = 5'h01
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [15:0] rx_page,
  input wire rx_page_valid,
  input wire tbi_link_ok,
  input wire strap_load_done,
  input wire strap_tbi,
  input wire local_pause,
  output reg mdc,
  output reg mdio_o,
  output reg mdio_oe,
  input wire mdio_i,
  input wire [13:0] rx_frame_len,
  input wire rx_frame_end,
  output reg rx_frame_accept,
  output reg rx_frame_drop,
  input wire [31:0] dma_addr_hi,
  output wire use_dual_addr,
  output wire big_endian,
  output wire rx_tag_strip_en,
  output wire rx_csum_offload_en,
  output wire multi_burst_cmd_en,
  output wire [63:0] rx_desc_ring_base
);

  reg [15:0] tbi_partner_ability;
  reg [15:0] last_page;
  reg [1:0] match_count;
  reg ten_bit_iface_sel;
  reg [15:0] rx_max_length;
  reg [15:0] extended_command;
  reg [31:0] ring_lo;
  reg [31:0] ring_hi;
  reg [15:0] poll_data [0:`MLSC_POLL_REGS-1];
  reg [4:0] div_count;
  reg [5:0] bit_count;
  reg [2:0] poll_idx;
  reg [15:0] shift_in;
  reg [13:0] header;
  reg [31:0] next_prdata;
  reg [7:0] phy_link_summary;
  reg link_up;
  reg full_duplex_flag;
  reg speed_gig_full;
  reg speed_hundred;
  reg speed_ten;
  reg pause_ok;
  wire wr_acc;
  wire rd_setup;
  wire mapped;
  wire mdc_rise;
  wire mdc_fall;
  wire [4:0] mdc_half;
  wire [4:0] mdc_last;
  wire [5:0] frame_last;
  wire [2:0] poll_last;
  wire [31:0] rxmax_merged;

  // Byte-lane merge used by every writable register except the command register
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
          lane_merge[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
  endfunction

  // Order in which PHY management registers are polled
  function [4:0] poll_reg_addr;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: poll_reg_addr = 5'h00;
        3'h1: poll_reg_addr = 5'h01;
        3'h2: poll_reg_addr = 5'h04;
        3'h3: poll_reg_addr = 5'h05;
        3'h4: poll_reg_addr = 5'h09;
        3'h5: poll_reg_addr = 5'h0A;
        default: poll_reg_addr = 5'h00;
      endcase
    end
  endfunction

  function is_mapped;
    input [11:0] a;
    begin
      case (a)
        `MLSC_ADDR_PARTNER,
        `MLSC_ADDR_PHYSTAT,
        `MLSC_ADDR_RXMAX,
        `MLSC_ADDR_CMD,
        `MLSC_ADDR_RING_LO,
        `MLSC_ADDR_RING_HI: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Zero-wait slave; read data registered in the setup cycle
  assign pready = 1'b1;
  assign mapped = is_mapped(paddr);
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  assign big_endian = extended_command[`MLSC_CMD_ENDIAN];
  assign rx_tag_strip_en = extended_command[`MLSC_CMD_VLAN];
  assign rx_csum_offload_en = extended_command[`MLSC_CMD_CSUM];
  assign multi_burst_cmd_en = extended_command[`MLSC_CMD_MULTI];
  assign use_dual_addr = extended_command[`MLSC_CMD_DAC]
                         & (|dma_addr_hi);
  assign rx_desc_ring_base = {ring_hi, ring_lo};
  assign rxmax_merged = lane_merge({16'h0000, rx_max_length}, pwdata, pstrb)
                        & {16'h0000, `MLSC_RXMAX_MASK};

  always @*
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `MLSC_ADDR_PARTNER: next_prdata = {16'h0000, tbi_partner_ability};
      `MLSC_ADDR_PHYSTAT: next_prdata = {24'h000000, phy_link_summary};
      `MLSC_ADDR_RXMAX: next_prdata = {16'h0000, rx_max_length};
      `MLSC_ADDR_CMD: next_prdata = {16'h0000, extended_command};
      `MLSC_ADDR_RING_LO: next_prdata = ring_lo;
      `MLSC_ADDR_RING_HI: next_prdata = ring_hi;
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= next_prdata;
  end

  // Writable registers; read-only offsets simply have no write path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_max_length <= `MLSC_RXMAX_RESET;
      extended_command <= `MLSC_CMD_RESET;
      ring_lo <= 32'h00000000;
      ring_hi <= 32'h00000000;
    end
    else if (wr_acc)
    begin
      case (paddr)
        `MLSC_ADDR_RXMAX:
          rx_max_length <= rxmax_merged[15:0];
        `MLSC_ADDR_CMD:
        begin
          // Needs byte lanes 1:0 both enabled; lone byte writes leave it alone
          if (pstrb[1:0] == 2'b11)
            extended_command <= pwdata[15:0] & `MLSC_CMD_MASK;
        end
        `MLSC_ADDR_RING_LO:
          ring_lo <= lane_merge(ring_lo, pwdata, pstrb)
                     & `MLSC_RING_LO_MASK;
        `MLSC_ADDR_RING_HI:
          ring_hi <= lane_merge(ring_hi, pwdata, pstrb);
        default:
          ring_hi <= ring_hi;
      endcase
    end
  end

  // Page arbitration: accept a page once seen three times in a row
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbi_partner_ability <= 16'h0000;
      last_page <= 16'h0000;
      match_count <= 2'h0;
    end
    else if (rx_page_valid)
    begin
      last_page <= rx_page;
      // First page after reset has nothing to match against
      if (match_count != 2'h0
          && (rx_page | 16'h4000) == (last_page | 16'h4000))
      begin
        if (match_count != `MLSC_PAGE_MATCHES)
          match_count <= match_count + 2'h1;
        if (match_count >= `MLSC_PAGE_MATCHES - 2'h1)
          tbi_partner_ability <= rx_page & `MLSC_LP_MASK;
      end
      else
        match_count <= 2'h1;
    end
  end

  // Strap caught by a clocked process when the serial load finishes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ten_bit_iface_sel <= 1'b0;
    else if (strap_load_done)
      ten_bit_iface_sel <= strap_tbi;
  end

  // MDC divider: one full management clock every 32 pclk cycles
  localparam [31:0] MDC_HALF_W = `MLSC_MDC_HALF - 1;
  localparam [31:0] MDC_LAST_W = `MLSC_MDC_CYCLES - 1;
  localparam [31:0] FRAME_LAST_W = `MLSC_FRAME_BITS - 1;
  localparam [31:0] POLL_LAST_W = `MLSC_POLL_REGS - 1;
  localparam [31:0] PHY_ADDR_W = PHY_ADDR;
  assign mdc_half = MDC_HALF_W[4:0];
  assign mdc_last = MDC_LAST_W[4:0];
  assign mdc_rise = (div_count == mdc_half);
  assign mdc_fall = (div_count == mdc_last);
  assign frame_last = FRAME_LAST_W[5:0];
  assign poll_last = POLL_LAST_W[2:0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_count <= 5'h00;
      mdc <= 1'b0;
    end
    else
    begin
      div_count <= mdc_fall ? 5'h00 : div_count + 5'h01;
      if (mdc_rise)
        mdc <= 1'b1;
      else if (mdc_fall)
        mdc <= 1'b0;
    end
  end

  // Read frames: preamble, start, opcode, addresses, turnaround, data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_count <= 6'h00;
      poll_idx <= 3'h0;
      shift_in <= 16'h0000;
      header <= 14'h0000;
      mdio_o <= 1'b1;
      mdio_oe <= 1'b0;
    end
    else
    begin
      if (mdc_fall)
      begin
        if (bit_count == frame_last)
        begin
          bit_count <= 6'h00;
          poll_idx <= (poll_idx == poll_last) ? 3'h0 : poll_idx + 3'h1;
        end
        else
          bit_count <= bit_count + 6'h01;
        if (bit_count == frame_last || bit_count < 6'd31)
        begin
          mdio_o <= 1'b1;
          mdio_oe <= 1'b1;
        end
        else if (bit_count < 6'd45)
        begin
          if (bit_count == 6'd31)
          begin
            header <= {4'b0110, PHY_ADDR_W[4:0], poll_reg_addr(poll_idx)};
            mdio_o <= 1'b0;
          end
          else
          begin
            header <= {header[12:0], 1'b0};
            mdio_o <= header[12];
          end
          mdio_oe <= 1'b1;
        end
        else
        begin
          mdio_o <= 1'b1;
          mdio_oe <= 1'b0;
        end
      end
      if (mdc_rise && bit_count >= `MLSC_DATA_FIRST)
        shift_in <= {shift_in[14:0], mdio_i};
    end
  end

  integer k;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (k = 0; k < `MLSC_POLL_REGS; k = k + 1)
        poll_data[k] <= 16'h0000;
    end
    else if (mdc_fall && bit_count == frame_last)
      poll_data[poll_idx] <= shift_in;
  end

  // Resolve link, speed and duplex from the polled results; in ten-bit mode link and duplex come from tbi_link_ok and partner ability
  always @*
  begin
    pause_ok = local_pause & tbi_partner_ability[`MLSC_LP_SYM];
    speed_gig_full = 1'b0;
    speed_hundred = 1'b0;
    speed_ten = 1'b0;
    if (ten_bit_iface_sel)
    begin
      link_up = tbi_link_ok;
      full_duplex_flag = tbi_partner_ability[`MLSC_LP_FULL];
    end
    else
    begin
      link_up = poll_data[1][2];
      if (poll_data[4][9] && poll_data[5][11])
      begin
        speed_gig_full = 1'b1;
        full_duplex_flag = 1'b1;
      end
      else if (poll_data[2][8] && poll_data[3][8])
      begin
        speed_hundred = 1'b1;
        full_duplex_flag = 1'b1;
      end
      else if (poll_data[2][7] && poll_data[3][7])
      begin
        speed_hundred = 1'b1;
        full_duplex_flag = 1'b0;
      end
      else
      begin
        speed_ten = 1'b1;
        full_duplex_flag = poll_data[2][6] & poll_data[3][6];
      end
      pause_ok = local_pause & poll_data[3][10];
    end
  end

  // Summary is refreshed every cycle from the strap and the resolved link, speed, duplex and pause
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phy_link_summary <= 8'h00;
    else
      phy_link_summary <= {ten_bit_iface_sel,
        pause_ok & full_duplex_flag & link_up,
        pause_ok & full_duplex_flag & link_up,
        speed_gig_full & link_up,
        speed_hundred & link_up,
        speed_ten & link_up,
        link_up,
        full_duplex_flag & link_up};
  end

  // Frame length check against the programmed maximum
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_frame_accept <= 1'b0;
      rx_frame_drop <= 1'b0;
    end
    else
    begin
      rx_frame_accept <= rx_frame_end && rx_max_length[13:0] != 14'h0000
                         && rx_frame_len <= rx_max_length[13:0];
      rx_frame_drop <= rx_frame_end && (rx_max_length[13:0] == 14'h0000
                       || rx_frame_len > rx_max_length[13:0]);
    end
  end

endmodule

// ==== hw/mlsc_defines.vh ====
/*
 Constants for the MAC link status and configuration register slice:
 register indexes, byte addresses, field positions, reset values and
 the management polling timing. Assumes a 100 MHz register clock.
*/
`ifndef MLSC_DEFINES_VH
`define MLSC_DEFINES_VH

// Register indexes; byte address is four times the index
`define MLSC_IDX_PARTNER 12'h06A
`define MLSC_IDX_PHYSTAT 12'h06C
`define MLSC_IDX_RXMAX 12'h0DA
`define MLSC_IDX_CMD 12'h0E0
`define MLSC_IDX_RING_LO 12'h0E4
`define MLSC_IDX_RING_HI 12'h0E8
`define MLSC_ADDR_PARTNER 12'h1A8
`define MLSC_ADDR_PHYSTAT 12'h1B0
`define MLSC_ADDR_RXMAX 12'h368
`define MLSC_ADDR_CMD 12'h380
`define MLSC_ADDR_RING_LO 12'h390
`define MLSC_ADDR_RING_HI 12'h3A0

// Partner ability fields
`define MLSC_LP_NEXT 15
`define MLSC_LP_ACK 14
`define MLSC_LP_RF_HI 13
`define MLSC_LP_RF_LO 12
`define MLSC_LP_ASYM 8
`define MLSC_LP_SYM 7
`define MLSC_LP_HALF 6
`define MLSC_LP_FULL 5
`define MLSC_LP_MASK 16'hF1E0

// Command fields
`define MLSC_CMD_ENDIAN 9
`define MLSC_CMD_VLAN 6
`define MLSC_CMD_CSUM 5
`define MLSC_CMD_DAC 4
`define MLSC_CMD_MULTI 3
`define MLSC_CMD_MASK 16'h0278
`define MLSC_CMD_RESET 16'h0000

`define MLSC_RXMAX_MASK 16'h3FFF
`define MLSC_RXMAX_RESET 16'h0000
`define MLSC_RING_LO_MASK 32'hFFFFFF00
`define MLSC_PAGE_MATCHES 2'h3

// Management polling timing
`define MLSC_CLK_PERIOD_NS 10
`define MLSC_MDC_PERIOD_NS 320
`define MLSC_MDC_CYCLES (`MLSC_MDC_PERIOD_NS / `MLSC_CLK_PERIOD_NS)
`define MLSC_MDC_HALF (`MLSC_MDC_CYCLES / 2)
`define MLSC_PREAMBLE_BITS 32
`define MLSC_FRAME_BITS 64
`define MLSC_POLL_REGS 6
`define MLSC_TA_FIRST 46
`define MLSC_DATA_FIRST 48

`endif

// ==== testbench/mlsc_regs_asserts.sv ====
/*
 Checker on the ports of the register slice.
 Bound to every mlsc_regs instance below.
*/
`timescale 1ns/1ps
`include "mlsc_defines.vh"
module mlsc_regs_asserts (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic mdc,
  input logic rx_frame_end,
  input logic rx_frame_accept,
  input logic rx_frame_drop,
  input logic [31:0] dma_addr_hi,
  input logic use_dual_addr,
  input logic big_endian,
  input logic rx_tag_strip_en,
  input logic rx_csum_offload_en,
  input logic multi_burst_cmd_en,
  input logic [63:0] rx_desc_ring_base
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic hit;
  logic cw;
  logic [3:0] cmd;
  assign acc = psel && penable;
  assign cw = acc && pwrite && paddr == `MLSC_ADDR_CMD;
  assign cmd = {big_endian, rx_tag_strip_en, rx_csum_offload_en,
    multi_burst_cmd_en};
  assign hit = paddr inside {`MLSC_ADDR_PARTNER, `MLSC_ADDR_PHYSTAT,
    `MLSC_ADDR_RXMAX, `MLSC_ADDR_CMD, `MLSC_ADDR_RING_LO,
    `MLSC_ADDR_RING_HI};
  err_map_a: assert property (acc |-> pslverr == !hit)
    else $error("slave error disagrees with address map");
  frame_verdict_a: assert property (rx_frame_end |=> rx_frame_accept != rx_frame_drop)
    else $error("frame end without single verdict");
  no_stray_a: assert property (!rx_frame_end |=> !rx_frame_accept && !rx_frame_drop)
    else $error("verdict without frame end");
  dual_addr_a: assert property (use_dual_addr |-> dma_addr_hi != 32'h0)
    else $error("dual address with zero upper half");
  ring_align_a: assert property (rx_desc_ring_base[7:0] == 8'h00)
    else $error("ring base not aligned");
  byte_write_a: assert property (cw && pstrb[1:0] != 2'h3 |=> $stable(cmd))
    else $error("partial command write took effect");
  cmd_write_a: assert property (cw && pstrb[1:0] == 2'h3 |=> cmd == {$past(pwdata[9]), $past(pwdata[6]), $past(pwdata[5]), $past(pwdata[3])})
    else $error("command levels differ from write");
  cmd_read_a: assert property (acc && !pwrite && paddr == `MLSC_ADDR_CMD |-> (prdata & 32'hFFFFFD87) == 32'h0)
    else $error("reserved command bits read nonzero");
  rxmax_read_a: assert property (acc && !pwrite && paddr == `MLSC_ADDR_RXMAX |-> prdata[31:14] == 18'h0)
    else $error("rx max upper bits nonzero");
  mdc_half_a: assert property ($rose(mdc) |-> ##16 $fell(mdc))
    else $error("management clock half period wrong");
  cover property (acc && pslverr);
  cover property (rx_frame_accept);
  cover property (use_dual_addr);
endmodule
bind mlsc_regs mlsc_regs_asserts chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .mdc, .rx_frame_end,
  .rx_frame_accept, .rx_frame_drop, .dma_addr_hi, .use_dual_addr,
  .big_endian, .rx_tag_strip_en, .rx_csum_offload_en, .multi_burst_cmd_en,
  .rx_desc_ring_base);

// ==== testbench/mlsc_phy_model.sv ====
/*
 Behavioural PHY on the management bus, answering register reads.
 Assumes the bench resolves the line with a pull-up.
*/
`timescale 1ns/1ps
module mlsc_phy_model #(
  parameter logic [4:0] ADDR = 5'h01
) (
  input logic mdc,
  input logic mdio_o,
  input logic mdio_oe,
  input logic link,
  input logic gig,
  output logic phy_oe,
  output logic phy_o
);
  logic [12:0] sh = '0;
  logic [15:0] rd = '0;
  int cnt = 0;
  function automatic logic [15:0] reg_val(input logic [4:0] r);
    case (r)
      5'h01: return {13'h0, link, 2'h0};
      5'h04: return {7'h0, !gig, 8'h00};
      // Partner side always advertises symmetric pause
      5'h05: return {5'h0, 1'b1, 1'b0, !gig, 8'h00};
      5'h09: return {6'h0, gig, 9'h000};
      5'h0A: return {4'h0, gig, 11'h000};
      default: return 16'h0000;
    endcase
  endfunction
  initial phy_oe = 1'b0;
  initial phy_o = 1'b0;
  always @(posedge mdc or negedge mdc)
  begin
    if (mdc && mdio_oe)
    begin
      sh <= {sh[11:0], mdio_o};
      if (cnt == 0 && sh[12:4] == {4'h6, ADDR})
      begin
        rd <= reg_val({sh[3:0], mdio_o});
        cnt <= 1;
      end
    end
    else if (!mdc && cnt != 0)
    begin
      // Released after the last data bit so the pull-up shows
      cnt <= (cnt == 19) ? 0 : cnt + 1;
      phy_oe <= cnt >= 2 && cnt <= 18;
      phy_o <= (cnt > 2 && cnt < 19) ? rd[18 - cnt] : 1'b0;
    end
  end
endmodule

// ==== testbench/tb.sv ====
/*
 Self-checking bench for the register slice, one task per scenario.
 Polls pready in each access, failing after 20 cycles, and assumes a pulled-up MDIO line.
*/
`timescale 1ns/1ps
`include "mlsc_defines.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, dma_addr_hi = '0, r;
  logic [3:0] pstrb = '0;
  logic [15:0] rx_page = '0;
  logic rx_page_valid = 0, tbi_link_ok = 0, strap_load_done = 0;
  logic strap_tbi = 0, local_pause = 0, rx_frame_end = 0, e;
  logic [13:0] rx_frame_len = '0;
  logic link = 0, gig = 1;
  wire pready, pslverr, mdc, mdio_o, mdio_oe, phy_oe, phy_o;
  wire rx_frame_accept, rx_frame_drop, use_dual_addr, big_endian;
  wire rx_tag_strip_en, rx_csum_offload_en, multi_burst_cmd_en;
  wire [31:0] prdata;
  wire [63:0] rx_desc_ring_base;
  wire mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  int failures = 0, comparisons = 0;
  mlsc_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .rx_page, .rx_page_valid,
    .tbi_link_ok, .strap_load_done, .strap_tbi, .local_pause, .mdc,
    .mdio_o, .mdio_oe, .mdio_i, .rx_frame_len, .rx_frame_end,
    .rx_frame_accept, .rx_frame_drop, .dma_addr_hi, .use_dual_addr,
    .big_endian, .rx_tag_strip_en, .rx_csum_offload_en,
    .multi_burst_cmd_en, .rx_desc_ring_base);
  mlsc_phy_model phy_u (.mdc, .mdio_o, .mdio_oe, .link, .gig, .phy_oe,
    .phy_o);
  initial forever #5 pclk = ~pclk;
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] x, g);
    comparisons++;
    if (g !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      close_out;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
    input string nm);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, x, r);
  endtask
  task automatic fr(input logic [13:0] len, input logic ok,
    input string nm);
    rx_frame_len <= len;
    rx_frame_end <= 1'b1;
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    #1;
    chk(nm, {ok, !ok}, {rx_frame_accept, rx_frame_drop});
    @(posedge pclk);
  endtask
  task automatic pg(input logic [15:0] p);
    rx_page <= p;
    rx_page_valid <= 1'b1;
    @(posedge pclk);
    rx_page_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_st(input logic [7:0] x, input string nm);
    int n;
    n = 0;
    // Polling round is long, so look only every hundred cycles
    do
    begin
      repeat (100) @(posedge pclk);
      apb(1'b0, `MLSC_ADDR_PHYSTAT, 32'h0, 4'h0);
      n++;
    end
    while (r !== {24'h0, x} && n < 200);
    chk(nm, {24'h0, x}, r);
    if (r !== {24'h0, x})
      close_out;
  endtask
  task automatic t_reset;
    rdc(`MLSC_ADDR_PARTNER, 32'h0, "ability reset");
    rdc(`MLSC_ADDR_CMD, 32'h0, "command reset");
    rdc(`MLSC_ADDR_PHYSTAT, 32'h0, "status reset");
    apb(1'b1, `MLSC_ADDR_PARTNER, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, `MLSC_ADDR_PHYSTAT, 32'hFFFFFFFF, 4'hF);
    chk("ro write error", 1'b0, e);
    rdc(`MLSC_ADDR_PARTNER, 32'h0, "ability after write");
    rdc(12'h3FC, 32'h0, "unmapped data");
    chk("unmapped error", 1'b1, e);
    $display("test reset done");
  endtask
  task automatic t_cmd;
    apb(1'b1, `MLSC_ADDR_CMD, 32'h0000FFFF, 4'h3);
    rdc(`MLSC_ADDR_CMD, 32'h0278, "command mask");
    chk("cmd levels", 4'hF, {big_endian, rx_tag_strip_en, rx_csum_offload_en, multi_burst_cmd_en});
    dma_addr_hi <= 32'h1;
    @(posedge pclk);
    chk("dual addr", 1'b1, use_dual_addr);
    apb(1'b1, `MLSC_ADDR_CMD, 32'h0, 4'h1);
    rdc(`MLSC_ADDR_CMD, 32'h0278, "byte write");
    apb(1'b1, `MLSC_ADDR_CMD, 32'h0, 4'h3);
    chk("cmd cleared", 5'h0, {big_endian, rx_tag_strip_en, rx_csum_offload_en, multi_burst_cmd_en, use_dual_addr});
    $display("test command done");
  endtask
  task automatic t_ring;
    apb(1'b1, `MLSC_ADDR_RING_LO, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, `MLSC_ADDR_RING_HI, 32'h89ABCDEF, 4'hF);
    rdc(`MLSC_ADDR_RING_LO, 32'hFFFFFF00, "ring lo");
    chk("ring out", 64'h89ABCDEF_FFFFFF00, rx_desc_ring_base);
    apb(1'b1, `MLSC_ADDR_RING_HI, 32'h0, 4'h1);
    rdc(`MLSC_ADDR_RING_HI, 32'h89ABCD00, "ring hi lane");
    $display("test ring done");
  endtask
  task automatic t_rxmax;
    fr(14'h0001, 1'b0, "max zero");
    apb(1'b1, `MLSC_ADDR_RXMAX, 32'hFFFFFFFF, 4'hF);
    rdc(`MLSC_ADDR_RXMAX, 32'h3FFF, "max mask");
    fr(14'h3FFF, 1'b1, "max len");
    apb(1'b1, `MLSC_ADDR_RXMAX, 32'h64, 4'hF);
    fr(14'h0064, 1'b1, "at limit");
    fr(14'h0065, 1'b0, "over limit");
    $display("test rx max done");
  endtask
  task automatic t_page;
    logic [15:0] p, old;
    old = 16'h0;
    for (int i = 0; i < 4; i++)
    begin
      p = {2'h2, i[1:0], 3'h0, i[1:0], i[0], 6'h20};
      pg(p);
      pg(p);
      rdc(`MLSC_ADDR_PARTNER, {16'h0, old}, "two pages");
      pg(p | 16'h4000);
      old = (p | 16'h4000) & `MLSC_LP_MASK;
      rdc(`MLSC_ADDR_PARTNER, {16'h0, old}, "ability");
    end
    $display("test page done");
  endtask
  task automatic t_status;
    local_pause <= 1'b1;
    link <= 1'b1;
    wait_st(8'h73, "gig link");
    link <= 1'b0;
    wait_st(8'h00, "link down");
    gig <= 1'b0;
    link <= 1'b1;
    wait_st(8'h6B, "hundred full");
    strap_tbi <= 1'b1;
    strap_load_done <= 1'b1;
    tbi_link_ok <= 1'b1;
    @(posedge pclk);
    strap_load_done <= 1'b0;
    wait_st(8'hE3, "ten bit mode");
    $display("test status done");
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_cmd;
    t_ring;
    t_rxmax;
    t_page;
    t_status;
    close_out;
  end
endmodule
